// *** src/opmode_params.svh ***
// Purpose: constants for the operation-mode controller
// Assumes: 50 MHz mclk
// Notes: register offsets are byte addresses on the plain port
`ifndef OPMODE_PARAMS_SVH
`define OPMODE_PARAMS_SVH

// Timing
`define CLK_PERIOD_NS 20
`define FIX_PERIOD_NS 10000000

// Widths
`define ADDR_W 4
`define DATA_W 32
`define SCANS_W 16
`define NINT 8

// Register offsets
`define A_CTRL 4'h0
`define A_SCANS 4'h4
`define A_INTEN 4'h8
`define A_STAT 4'hC

// Control fields
`define F_COND 1:0
`define F_WATCH 3:2
`define F_GO 4

// Status fields
`define S_MODE 1:0
`define S_EXEC 3:2
`define S_REM 4
`define S_HALT 5
`define S_PERR 6
`define S_MERR 7

// Reset values
`define RST_SCANS 16'h0001
`define RST_INTEN 8'hFF

`endif

// *** src/opmode_pkg.sv ***
// Purpose: types for the operation-mode controller
// Assumes: nothing
// Notes: enum order sets the encodings seen in status
package opmode_pkg;

	typedef enum logic [1:0] {MODE_STOP, MODE_RUN, MODE_DEBUG} mode_e;

	typedef enum logic [1:0] {CMD_RUN, CMD_STOP, CMD_DEBUG, CMD_LOAD} cmd_e;

	typedef enum logic [1:0] {EX_IDLE, EX_SCAN, EX_FIX, EX_DEV} exec_e;

	typedef enum logic [1:0] {DC_STEP, DC_BREAK, DC_WATCH, DC_SCANS} dbg_cond_e;

	typedef enum logic [1:0] {W_READ, W_WRITE, W_VALUE} watch_e;

	typedef enum logic [3:0] {
		PH_STOP, PH_STOP_CLR, PH_STOP_REF,
		PH_RUN_INIT, PH_RUN_CHK, PH_RUN,
		PH_DBG_INIT, PH_DBG_CLR, PH_DBG_INREF, PH_DBG
	} phase_e;

endpackage : opmode_pkg

// *** src/plc_operation_mode_control.sv ***
// Purpose: run/stop/debug mode control and scan/task scheduling
// Assumes: one clock, synchronous inputs, engine pulses one cycle long
// Notes: engine obeys exec_en and exec_sel; registers on a plain port
// Operation
// - Run entry: init data, then check program
// - Run: refresh I/O, run program, interrupts; code raises neither in_refresh nor out_refresh in Run
// - Run: watch modules, keep communication serviced
// - Stop entry: halt, clear outputs, refresh
// - Download only in remote Stop
// - Debug entry only from Stop
// - Debug entry: init data, clear outputs, input refresh
// - Debug: output refresh after program end
// - Four debug conditions, changeable while halted
// - Single step: one unit then halt
// - Break point reached: halt
// - Watched contact access matches: halt
// - Assigned scan count done: halt
// - Debug: per-unit interrupt enable mask
// - Remote commands need remote-enable on, switch Stop; code accepts download on the remote flag alone
// - Remote Run to local Run: no interruption
// - Stop instruction enters Stop mode
// - Fixed-cycle task preempts scan, then resumes
// - Device task sampled only at scan end
// - Fixed task preempts device task, which finishes
`timescale 1ns/100ps
`include "opmode_params.svh"

module plc_operation_mode_control
	import opmode_pkg::*;
#(
	parameter int FIX_CYC = `FIX_PERIOD_NS / `CLK_PERIOD_NS,
	parameter int NINT = `NINT,
	parameter int SCANS_W = `SCANS_W
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Operator switches
	input wire logic sw_run,
	input wire logic remote_en,
	// Host commands
	input wire logic cmd_valid,
	input wire cmd_e cmd_code,
	output logic cmd_ok,
	output logic cmd_rej,
	// Register port
	input wire logic [`ADDR_W-1:0] addr,
	input wire logic [`DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [`DATA_W-1:0] rdata,
	// Engine status
	input wire logic prog_valid,
	input wire logic prog_end,
	input wire logic task_end,
	input wire logic stop_instr,
	input wire logic unit_done,
	input wire logic bp_hit,
	input wire logic acc_rd,
	input wire logic acc_wr,
	input wire logic acc_val,
	input wire logic dev_req,
	input wire logic [NINT-1:0] intr_req,
	input wire logic mod_fault,
	// Engine control
	output mode_e mode_out,
	output logic init_data,
	output logic clr_out_img,
	output logic out_refresh,
	output logic in_refresh,
	output logic scan_start,
	output logic exec_en,
	output exec_e exec_sel,
	output logic [NINT-1:0] intr_grant,
	output logic comm_en
);

	localparam int TW = $clog2(FIX_CYC);

	function automatic mode_e mode_of(input phase_e p);
		case (p)
			PH_RUN_INIT, PH_RUN_CHK, PH_RUN: mode_of = MODE_RUN;
			PH_DBG_INIT, PH_DBG_CLR, PH_DBG_INREF, PH_DBG: mode_of = MODE_DEBUG;
			default: mode_of = MODE_STOP;
		endcase
	endfunction : mode_of

	phase_e ph_ff, nxt_ph;
	exec_e exec_ff, saved_ff;
	dbg_cond_e cond_ff;
	watch_e watch_ff;
	logic remote_ff, nxt_remote, sw_prev_ff, halt_ff, fix_pend_ff;
	logic perr_ff, merr_ff, scan_start_ff, exec_en_ff;
	logic init_ff, clr_ff, oref_ff, iref_ff, ok_ff, rej_ff, comm_ff;
	logic [TW-1:0] tmr_ff;
	logic [SCANS_W-1:0] scans_ff, scan_cnt_ff;
	logic [NINT-1:0] inten_ff, grant_ff;
	logic [`DATA_W-1:0] rdata_ff, rd_word;
	logic sw_fall, sw_rise, rem_ok, stopping, in_run;
	logic c_run, c_stop, c_dbg, dl_ok, go_stop;
	logic dbg_run, runnable, hit, go, tick, fix_take, stat_wr;

	// Switch edges and command qualification
	assign sw_fall = sw_prev_ff & ~sw_run;
	assign sw_rise = ~sw_prev_ff & sw_run;
	assign rem_ok = ~sw_run & remote_en;
	assign c_run = cmd_valid & rem_ok & (cmd_code == CMD_RUN);
	assign c_stop = cmd_valid & rem_ok & (cmd_code == CMD_STOP);
	assign c_dbg = cmd_valid & rem_ok & (cmd_code == CMD_DEBUG) & (ph_ff == PH_STOP);
	assign dl_ok = cmd_valid & (cmd_code == CMD_LOAD) & (ph_ff == PH_STOP) & remote_ff;
	assign stopping = mode_of(ph_ff) == MODE_STOP;
	assign in_run = mode_of(ph_ff) == MODE_RUN;
	assign go_stop = (sw_fall & ~stopping) | (stop_instr & exec_en_ff) | c_stop;

	always_ff @(posedge mclk) begin
		if (rst) begin
			sw_prev_ff <= 1'b0;
		end else begin
			sw_prev_ff <= sw_run;
		end
	end

	// Mode sequencing
	always_comb begin
		nxt_ph = ph_ff;
		nxt_remote = remote_ff;
		case (ph_ff)
			PH_RUN_INIT: nxt_ph = PH_RUN_CHK;
			PH_RUN_CHK: nxt_ph = prog_valid ? PH_RUN : PH_STOP_CLR;
			PH_STOP_CLR: nxt_ph = PH_STOP_REF;
			PH_STOP_REF: nxt_ph = PH_STOP;
			PH_DBG_INIT: nxt_ph = PH_DBG_CLR;
			PH_DBG_CLR: nxt_ph = PH_DBG_INREF;
			PH_DBG_INREF: nxt_ph = PH_DBG;
			default: nxt_ph = ph_ff;
		endcase
		if (go_stop) begin
			// Switch stop beats everything, remote flag dropped
			if (!stopping) begin
				nxt_ph = PH_STOP_CLR;
			end
			if (sw_fall) begin
				nxt_remote = 1'b0;
			end else if (c_stop) begin
				nxt_remote = 1'b1;
			end
		end else if (sw_rise) begin
			// Already running remotely: keep scanning, just go local
			if (!in_run) begin
				nxt_ph = PH_RUN_INIT;
			end
			nxt_remote = 1'b0;
		end else if (c_run & ~in_run) begin
			nxt_ph = PH_RUN_INIT;
			nxt_remote = 1'b1;
		end else if (c_dbg) begin
			nxt_ph = PH_DBG_INIT;
			nxt_remote = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			ph_ff <= PH_STOP;
			remote_ff <= 1'b0;
		end else begin
			ph_ff <= nxt_ph;
			remote_ff <= nxt_remote;
		end
	end

	// Command answers; refused commands leave the mode alone
	always_ff @(posedge mclk) begin
		if (rst) begin
			ok_ff <= 1'b0;
			rej_ff <= 1'b0;
		end else begin
			ok_ff <= c_run | c_stop | c_dbg | dl_ok;
			rej_ff <= cmd_valid & ~(c_run | c_stop | c_dbg | dl_ok);
		end
	end

	// Sequence strobes, high while their phase lasts; debug output refresh is one cycle after prog_end
	always_ff @(posedge mclk) begin
		if (rst) begin
			init_ff <= 1'b0;
			clr_ff <= 1'b0;
			oref_ff <= 1'b0;
			iref_ff <= 1'b0;
			comm_ff <= 1'b0;
		end else begin
			init_ff <= (nxt_ph == PH_RUN_INIT) | (nxt_ph == PH_DBG_INIT);
			clr_ff <= (nxt_ph == PH_STOP_CLR) | (nxt_ph == PH_DBG_CLR);
			oref_ff <= (nxt_ph == PH_STOP_REF) | (dbg_run & prog_end);
			iref_ff <= nxt_ph == PH_DBG_INREF;
			comm_ff <= (nxt_ph == PH_RUN) | (nxt_ph == PH_STOP) | (nxt_ph == PH_DBG);
		end
	end

	// Debug halt control
	assign dbg_run = (ph_ff == PH_DBG) & ~halt_ff;
	assign runnable = (ph_ff == PH_RUN) | dbg_run;
	assign go = wr & (addr == `A_CTRL) & wdata[`F_GO];

	always_comb begin
		case (cond_ff)
			DC_STEP: hit = unit_done;
			DC_BREAK: hit = bp_hit;
			DC_WATCH: hit = ((watch_ff == W_READ) & acc_rd) | ((watch_ff == W_WRITE) & acc_wr)
				| ((watch_ff == W_VALUE) & acc_val);
			DC_SCANS: hit = prog_end & (exec_ff == EX_SCAN)
				& (SCANS_W'(scan_cnt_ff + 1'b1) == scans_ff);
			default: hit = 1'b0;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst || ph_ff != PH_DBG) begin
			halt_ff <= 1'b1;
		end else if (dbg_run & hit) begin
			halt_ff <= 1'b1;
		end else if (go) begin
			halt_ff <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst || ph_ff != PH_DBG || go) begin
			scan_cnt_ff <= '0;
		end else if (dbg_run & prog_end & exec_ff == EX_SCAN) begin
			scan_cnt_ff <= SCANS_W'(scan_cnt_ff + 1'b1);
		end
	end

	// Fixed-cycle timer, counting only while the program runs
	assign tick = runnable & (tmr_ff == TW'(FIX_CYC - 1));

	always_ff @(posedge mclk) begin
		if (rst || !runnable || tick) begin
			tmr_ff <= '0;
		end else begin
			tmr_ff <= TW'(tmr_ff + 1'b1);
		end
	end

	// Scan end has precedence so a finished scan is never lost
	assign fix_take = runnable & fix_pend_ff & (((exec_ff == EX_SCAN) & ~prog_end)
		| ((exec_ff == EX_DEV) & ~task_end));

	always_ff @(posedge mclk) begin
		if (rst || !(ph_ff == PH_RUN || ph_ff == PH_DBG)) begin
			fix_pend_ff <= 1'b0;
		end else begin
			// Request while the task runs is dropped; new tick beats clear
			fix_pend_ff <= (fix_pend_ff & ~fix_take) | (tick & exec_ff != EX_FIX);
		end
	end

	// Program scheduler
	always_ff @(posedge mclk) begin
		if (rst || !(ph_ff == PH_RUN || ph_ff == PH_DBG)) begin
			exec_ff <= EX_IDLE;
			saved_ff <= EX_SCAN;
			scan_start_ff <= 1'b0;
		end else begin
			scan_start_ff <= 1'b0;
			if (runnable) begin
				case (exec_ff)
					EX_IDLE: begin
						exec_ff <= EX_SCAN;
						scan_start_ff <= 1'b1;
					end
					EX_SCAN: begin
						if (prog_end) begin
							if (dev_req) begin
								exec_ff <= EX_DEV;
							end else begin
								scan_start_ff <= 1'b1;
							end
						end else if (fix_take) begin
							saved_ff <= EX_SCAN;
							exec_ff <= EX_FIX;
						end
					end
					EX_DEV: begin
						if (task_end) begin
							exec_ff <= EX_SCAN;
							scan_start_ff <= 1'b1;
						end else if (fix_take) begin
							saved_ff <= EX_DEV;
							exec_ff <= EX_FIX;
						end
					end
					EX_FIX: begin
						if (task_end) begin
							exec_ff <= saved_ff;
						end
					end
					default: exec_ff <= EX_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			exec_en_ff <= 1'b0;
			grant_ff <= '0;
		end else begin
			// Drop on the stop or halt edge itself, not one cycle late
			exec_en_ff <= runnable & (exec_ff != EX_IDLE) & ~go_stop & ~(dbg_run & hit);
			if (!runnable) begin
				grant_ff <= '0;
			end else if (ph_ff == PH_DBG) begin
				grant_ff <= intr_req & inten_ff;
			end else begin
				grant_ff <= intr_req;
			end
		end
	end

	// Register file
	assign stat_wr = wr & (addr == `A_STAT);

	always_ff @(posedge mclk) begin
		if (rst) begin
			cond_ff <= DC_STEP;
			watch_ff <= W_READ;
			scans_ff <= `RST_SCANS;
			inten_ff <= `RST_INTEN;
		end else if (wr) begin
			case (addr)
				`A_CTRL: begin
					cond_ff <= dbg_cond_e'(wdata[`F_COND]);
					watch_ff <= watch_e'(wdata[`F_WATCH]);
				end
				`A_SCANS: scans_ff <= wdata[SCANS_W-1:0];
				`A_INTEN: inten_ff <= wdata[NINT-1:0];
				default: ;
			endcase
		end
	end

	// Error flags: hardware set wins over a write-one clear
	always_ff @(posedge mclk) begin
		if (rst) begin
			perr_ff <= 1'b0;
			merr_ff <= 1'b0;
		end else begin
			perr_ff <= (ph_ff == PH_RUN_CHK & ~prog_valid)
				| (perr_ff & ~(stat_wr & wdata[`S_PERR]));
			merr_ff <= (mod_fault & ~stopping) | (merr_ff & ~(stat_wr & wdata[`S_MERR]));
		end
	end

	always_comb begin
		rd_word = '0;
		case (addr)
			`A_CTRL: begin
				rd_word[`F_COND] = cond_ff;
				rd_word[`F_WATCH] = watch_ff;
			end
			`A_SCANS: rd_word[SCANS_W-1:0] = scans_ff;
			`A_INTEN: rd_word[NINT-1:0] = inten_ff;
			`A_STAT: begin
				rd_word[`S_MODE] = mode_of(ph_ff);
				rd_word[`S_EXEC] = exec_ff;
				rd_word[`S_REM] = remote_ff;
				rd_word[`S_HALT] = halt_ff;
				rd_word[`S_PERR] = perr_ff;
				rd_word[`S_MERR] = merr_ff;
			end
			default: rd_word = '0;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst || !rd) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= rd_word;
		end
	end

	assign mode_out = mode_of(ph_ff);
	assign cmd_ok = ok_ff;
	assign cmd_rej = rej_ff;
	assign rdata = rdata_ff;
	assign init_data = init_ff;
	assign clr_out_img = clr_ff;
	assign out_refresh = oref_ff;
	assign in_refresh = iref_ff;
	assign scan_start = scan_start_ff;
	assign exec_en = exec_en_ff;
	assign exec_sel = exec_ff;
	assign intr_grant = grant_ff;
	assign comm_en = comm_ff;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	a_run_entry: assert property (
		ph_ff == PH_RUN_INIT && !go_stop |-> init_data ##1 (ph_ff == PH_RUN_CHK))
		else $error("run entry sequence broken");
	a_prog_check: assert property (
		ph_ff == PH_RUN_CHK && !go_stop
		|=> (ph_ff == PH_RUN) == $past(prog_valid) && (perr_ff || $past(prog_valid)))
		else $error("program check outcome wrong");
	a_stop_entry: assert property (
		(ph_ff == PH_STOP_CLR && !sw_rise && !c_run && !c_dbg)
		|-> clr_out_img && !exec_en ##1 out_refresh)
		else $error("stop entry must clear then refresh");
	a_load_gate: assert property (
		cmd_valid && cmd_code == CMD_LOAD && !(ph_ff == PH_STOP && remote_ff)
		|=> cmd_rej && !cmd_ok)
		else $error("download accepted outside remote stop");
	a_debug_gate: assert property (
		cmd_valid && cmd_code == CMD_DEBUG && ph_ff != PH_STOP
		|=> cmd_rej && ph_ff != PH_DBG_INIT)
		else $error("debug entered from non-stop");
	a_debug_entry: assert property (
		ph_ff == PH_DBG_INIT && !go_stop |-> init_data ##1 clr_out_img ##1 in_refresh)
		else $error("debug entry sequence broken");
	a_step_halt: assert property (
		dbg_run && cond_ff == DC_STEP && unit_done |=> halt_ff && !exec_en [*2])
		else $error("step did not halt");
	a_dbg_mask: assert property (
		ph_ff == PH_DBG |=> (intr_grant & ~$past(inten_ff)) == '0)
		else $error("masked interrupt granted");
	a_remote_gate: assert property (
		cmd_valid && cmd_code != CMD_LOAD && !rem_ok |=> cmd_rej)
		else $error("remote command not refused");
	a_switch_stop: assert property (
		sw_fall && in_run |=> ph_ff == PH_STOP_CLR ##2 ph_ff == PH_STOP || sw_rise)
		else $error("switch stop ignored");
	a_fix_preempt: assert property (
		fix_take && exec_ff == EX_SCAN |=> exec_ff == EX_FIX && saved_ff == EX_SCAN)
		else $error("fixed task did not preempt scan");
	a_dev_at_end: assert property (
		exec_ff == EX_SCAN && !prog_end |=> exec_ff != EX_DEV)
		else $error("device task started mid scan");

	c_fix_over_dev: cover property (exec_ff == EX_DEV ##1 exec_ff == EX_FIX);
	c_scan_halt: cover property (dbg_run && cond_ff == DC_SCANS && hit);
	c_remote_to_local: cover property (ph_ff == PH_RUN && remote_ff && sw_rise);

endmodule : plc_operation_mode_control

// *** tb/opmode_host_model.sv ***
// Purpose: remote host and operator switch model for the mode controller
// Assumes: signals change by non-blocking assignment right after rising edges
// Notes: code lines are scrambled while no command is offered
`timescale 1ns/100ps

module opmode_host_model
	import opmode_pkg::*;
(
	// Clock
	input wire logic mclk,
	// Operator switches
	output logic sw_run,
	output logic remote_en,
	// Host command
	output logic cmd_valid,
	output cmd_e cmd_code
);
	initial begin
		sw_run = 1'b0;
		remote_en = 1'b0;
		cmd_valid = 1'b0;
		cmd_code = CMD_LOAD;
	end

	// Idle code is the inverse of the last, so a stale code never matches by luck
	task send(input cmd_e c);
		@(posedge mclk);
		cmd_valid <= 1'b1;
		cmd_code <= c;
		@(posedge mclk);
		cmd_valid <= 1'b0;
		cmd_code <= cmd_e'(~c);
	endtask : send

	task set_remote(input logic v);
		@(posedge mclk);
		remote_en <= v;
	endtask : set_remote

	// Leaving remote run by the switch: raising it keeps running locally, dropping it stops
	task switch_stop(input int hold);
		@(posedge mclk);
		sw_run <= 1'b1;
		repeat (hold) @(posedge mclk);
		sw_run <= 1'b0;
	endtask : switch_stop
endmodule : opmode_host_model

// *** tb/plc_operation_mode_control_tb.sv ***
// Purpose: self-checking bench for the operation-mode controller
// Assumes: fixed-cycle period shortened to 50 clocks
// Notes: engine pulses come from one vector, one bit per event
`timescale 1ns/100ps
`include "opmode_params.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin bad_count++; $display("ERROR %0t: got %0h expected %0h", $time, a, b); end end

module plc_operation_mode_control_tb
	import opmode_pkg::*;
;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	wire logic sw_run;
	wire logic remote_en;
	wire logic cmd_valid;
	cmd_e cmd_code;
	logic cmd_ok, cmd_rej, wr, rd, prog_valid, dev_req;
	logic [`ADDR_W-1:0] addr;
	logic [`DATA_W-1:0] wdata, rdata, v;
	// 0 end,1 task end,2 stop,3 unit,4 break,5 rd,6 wr,7 value,8 fault
	logic [8:0] ev;
	logic [`NINT-1:0] intr_req, intr_grant;
	mode_e mode_out;
	exec_e exec_sel;
	logic init_data, clr_out_img, out_refresh, in_refresh, scan_start, exec_en, comm_en;
	int bad_count, n_compared, cyc, k, n;

	always #(`CLK_PERIOD_NS / 2) mclk = ~mclk;

	opmode_host_model HOST (.mclk(mclk), .sw_run(sw_run), .remote_en(remote_en),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code));

	plc_operation_mode_control #(.FIX_CYC(50)) DUT (
		.mclk(mclk), .rst(rst), .sw_run(sw_run), .remote_en(remote_en),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_ok(cmd_ok), .cmd_rej(cmd_rej),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.prog_valid(prog_valid), .prog_end(ev[0]), .task_end(ev[1]), .stop_instr(ev[2]),
		.unit_done(ev[3]), .bp_hit(ev[4]), .acc_rd(ev[5]), .acc_wr(ev[6]), .acc_val(ev[7]),
		.dev_req(dev_req), .intr_req(intr_req), .mod_fault(ev[8]),
		.mode_out(mode_out), .init_data(init_data), .clr_out_img(clr_out_img),
		.out_refresh(out_refresh), .in_refresh(in_refresh), .scan_start(scan_start),
		.exec_en(exec_en), .exec_sel(exec_sel), .intr_grant(intr_grant), .comm_en(comm_en));

	task final_report;
		if (bad_count == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : final_report

	// Whole run needs about 250 clocks
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			bad_count++;
			final_report();
		end
	end

	task wreg(input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] d);
		@(posedge mclk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge mclk);
		wr <= 1'b0;
	endtask : wreg

	task rreg(input logic [`ADDR_W-1:0] a, output logic [`DATA_W-1:0] d);
		@(posedge mclk);
		rd <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask : rreg

	task cmd(input cmd_e c, input logic ok);
		HOST.send(c);
		#1;
		`CHK({cmd_ok, cmd_rej}, {ok, ~ok})
	endtask : cmd

	task pulse(input int b);
		@(posedge mclk);
		ev[b] <= 1'b1;
		@(posedge mclk);
		ev <= '0;
		#1;
	endtask : pulse

	task halt_is(input logic h);
		rreg(`A_STAT, v);
		`CHK(v[5], h)
	endtask : halt_is

	// Image clear, then output refresh, then stopped
	task stop_seq;
		k = 0;
		while (clr_out_img !== 1'b1 && k < 4) begin
			@(posedge mclk);
			#1;
			k++;
		end
		`CHK({clr_out_img, exec_en}, 2'b10)
		@(posedge mclk);
		#1;
		`CHK(out_refresh, 1'b1)
		@(posedge mclk);
		#1;
		`CHK({mode_out, exec_en}, {MODE_STOP, 1'b0})
	endtask : stop_seq

	task wait_sel(input exec_e s, input exec_e bad);
		k = 0;
		while (exec_sel !== s && k < 200) begin
			@(posedge mclk);
			#1;
			`CHK(exec_sel !== bad, 1'b1)
			k++;
		end
		`CHK(exec_sel, s)
	endtask : wait_sel

	initial begin
		{wr, rd, prog_valid, dev_req} = 4'h0;
		addr = 4'h0;
		wdata = 32'h0;
		ev = '0;
		intr_req = '0;
		{cyc, bad_count, n_compared} = 0;
		n = $urandom(14);
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		rreg(`A_CTRL, v);
		`CHK(v, 32'h00000000)
		rreg(`A_SCANS, v);
		`CHK(v[15:0], `RST_SCANS)
		rreg(`A_INTEN, v);
		`CHK(v[7:0], `RST_INTEN)
		rreg(4'h2, v);
		`CHK(v, 32'h00000000)
		cmd(CMD_RUN, 1'b0);
		`CHK(mode_out, MODE_STOP)
		cmd(CMD_LOAD, 1'b0);
		HOST.set_remote(1'b1);
		cmd(CMD_RUN, 1'b1);
		`CHK(init_data, 1'b1)
		stop_seq();
		rreg(`A_STAT, v);
		`CHK(v[6], 1'b1)
		wreg(`A_STAT, 32'h40);
		rreg(`A_STAT, v);
		`CHK(v[6], 1'b0)
		@(posedge mclk);
		prog_valid <= 1'b1;
		cmd(CMD_RUN, 1'b1);
		`CHK({init_data, mode_out}, {1'b1, MODE_RUN})
		repeat (3) @(posedge mclk);
		#1;
		`CHK({scan_start, exec_sel}, {1'b1, EX_SCAN})
		@(posedge mclk);
		#1;
		`CHK({exec_en, comm_en}, 2'b11)
		v = $urandom;
		@(posedge mclk);
		intr_req <= v[7:0];
		repeat (2) @(posedge mclk);
		#1;
		`CHK(intr_grant, v[7:0])
		cmd(CMD_DEBUG, 1'b0);
		cmd(CMD_LOAD, 1'b0);
		pulse(8);
		rreg(`A_STAT, v);
		`CHK(v[7], 1'b1)
		@(posedge mclk);
		dev_req <= 1'b1;
		wait_sel(EX_FIX, EX_DEV);
		pulse(1);
		`CHK(exec_sel, EX_SCAN)
		pulse(0);
		`CHK(exec_sel, EX_DEV)
		@(posedge mclk);
		dev_req <= 1'b0;
		wait_sel(EX_FIX, EX_SCAN);
		pulse(1);
		`CHK(exec_sel, EX_DEV)
		pulse(1);
		`CHK({scan_start, exec_sel}, {1'b1, EX_SCAN})
		fork
			HOST.switch_stop(6);
			repeat (6) begin
				@(posedge mclk);
				#1;
				`CHK({mode_out, exec_en, clr_out_img}, {MODE_RUN, 2'b10})
			end
		join
		stop_seq();
		rreg(`A_STAT, v);
		`CHK(v[4:0], {1'b0, EX_IDLE, MODE_STOP})
		cmd(CMD_LOAD, 1'b0);
		cmd(CMD_RUN, 1'b1);
		repeat (5) @(posedge mclk);
		pulse(2);
		stop_seq();
		cmd(CMD_LOAD, 1'b1);
		cmd(CMD_DEBUG, 1'b1);
		`CHK(init_data, 1'b1)
		@(posedge mclk);
		#1;
		`CHK(clr_out_img, 1'b1)
		@(posedge mclk);
		#1;
		`CHK(in_refresh, 1'b1)
		@(posedge mclk);
		#1;
		`CHK(mode_out, MODE_DEBUG)
		halt_is(1'b1);
		cmd(CMD_DEBUG, 1'b0);
		cmd(CMD_LOAD, 1'b0);
		for (int c = 0; c < 4; c++) begin
			k = $urandom % 3;
			n = 1 + $urandom % 3;
			wreg(`A_SCANS, 32'(n));
			wreg(`A_CTRL, 32'(16 | (k << 2) | c));
			halt_is(1'b0);
			case (c)
				0: pulse(3);
				1: pulse(4);
				2: begin
					pulse(5 + (k + 1) % 3);
					halt_is(1'b0);
					pulse(5 + k);
				end
				default: for (int i = 0; i < n; i++) begin
					halt_is(1'b0);
					pulse(0);
					`CHK(out_refresh, 1'b1)
				end
			endcase
			halt_is(1'b1);
		end
		v = $urandom;
		wreg(`A_INTEN, v);
		// Grants only flow while debug runs, so resume first
		wreg(`A_CTRL, 32'h00000010);
		@(posedge mclk);
		intr_req <= v[15:8];
		repeat (2) @(posedge mclk);
		#1;
		`CHK(intr_grant, v[15:8] & v[7:0])
		cmd(CMD_STOP, 1'b1);
		stop_seq();
		final_report();
	end
endmodule : plc_operation_mode_control_tb
